/* File: mcs_pkg.sv */
// Package of register offsets, field positions, reset values and source codes for the carrier select block
package mcs_pkg;

	// ----------------------------------------------------------------
	// Register byte offsets on the APB bus
	// ----------------------------------------------------------------
	localparam logic [11:0] OFF_HIGH_CAR = 12'h000;
	localparam logic [11:0] OFF_LOW_CAR  = 12'h004;
	localparam logic [11:0] OFF_MOD_CON  = 12'h008;
	localparam logic [11:0] OFF_MOD_SRC  = 12'h00c;

	// ----------------------------------------------------------------
	// Carrier control fields
	// ----------------------------------------------------------------
	localparam int BIT_PIN_OFF = 7;
	localparam int BIT_INVERT  = 6;
	localparam int BIT_SYNC    = 5;
	localparam int BIT_UNUSED  = 4;
	localparam int SEL_LSB     = 0;
	localparam int SEL_W       = 4;

	// ----------------------------------------------------------------
	// Modulator control and source fields
	// ----------------------------------------------------------------
	localparam int BIT_ENABLE    = 7;
	localparam int BIT_PIN_OE    = 6;
	localparam int BIT_SLEW      = 5;
	localparam int BIT_OUT_POL   = 4;
	localparam int BIT_OUT_VALUE = 3;
	localparam int BIT_MANUAL    = 0;
	localparam int BIT_SRC_OFF   = 7;

	// ----------------------------------------------------------------
	// Writable masks and reset values
	// ----------------------------------------------------------------
	localparam logic [7:0] MASK_CAR = 8'hef;
	localparam logic [7:0] MASK_CON = 8'hf1;
	localparam logic [7:0] MASK_SRC = 8'h8f;
	localparam logic [7:0] RST_REG  = 8'h00;

	// ----------------------------------------------------------------
	// Source codes
	// ----------------------------------------------------------------
	localparam logic [3:0] CAR_GROUND  = 4'h0;
	localparam logic [3:0] CAR_PIN_ONE = 4'h1;
	localparam logic [3:0] CAR_PIN_TWO = 4'h2;
	localparam logic [3:0] CAR_REFCLK  = 4'h3;
	localparam logic [3:0] CAR_PWM_ONE = 4'h4;
	localparam int         N_CAR_SRC   = 8;
	localparam int         N_PWM       = 4;
	localparam logic [3:0] MOD_MANUAL  = 4'h0;
	localparam logic [3:0] MOD_PIN     = 4'h1;
	localparam int         MOD_PWM_LO  = 2;
	localparam int         N_MOD_SRC   = 11;

	typedef enum logic {MCS_ON_LOW, MCS_ON_HIGH} mcs_state_t;

endpackage

/* File: mcs_carrier_chan.sv */
// One carrier channel: source selection, PWM mode gating, inversion and pin drive disable
`timescale 1ns/1ps
module mcs_carrier_chan (
	input  wire logic                        mclk,
	input  wire logic                        rst_n,
	input  wire logic [3:0]                  sel,
	input  wire logic                        invert,
	input  wire logic                        drive_off,
	input  wire logic [mcs_pkg::N_CAR_SRC-1:0] src_in,
	input  wire logic [mcs_pkg::N_PWM-1:0]   pwm_mode,
	output logic                             carrier,
	output logic [mcs_pkg::N_CAR_SRC-1:0]    pin_off
);

	logic [mcs_pkg::N_CAR_SRC-1:0] gated;
	logic                          raw;

	// ----------------------------------------------------------------
	// Per source gating
	// ----------------------------------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi < mcs_pkg::N_CAR_SRC; gi++) begin : g_src
			if (gi == 0) begin : g_gnd
				assign gated[gi] = 1'b0;
			end else if (gi >= 4) begin : g_pwm
				assign gated[gi] = src_in[gi] & pwm_mode[gi-4];
			end else begin : g_plain
				assign gated[gi] = src_in[gi];
			end
			always_ff @(posedge mclk or negedge rst_n) begin
				if (!rst_n) begin
					pin_off[gi] <= 1'b0;
				end else begin
					pin_off[gi] <= drive_off & ~sel[3] & (sel[2:0] == 3'(gi));
				end
			end
		end
	endgenerate

	// Reserved codes connect nothing
	assign raw = sel[3] ? 1'b0 : gated[sel[2:0]];

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			carrier <= 1'b0;
		end else begin
			carrier <= raw ^ invert;
		end
	end

endmodule

/* File: mcs_carrier_select.sv */
// Top of the modulator carrier select block: APB registers, carrier channels, switching and output
//
// The address map and the APB register port were chosen for this implementation.
`timescale 1ns/1ps
module mcs_carrier_select (
	input  wire logic                         mclk,
	input  wire logic                         rst_n,
	input  wire logic                         psel,
	input  wire logic                         penable,
	input  wire logic                         pwrite,
	input  wire logic [11:0]                  paddr,
	input  wire logic [31:0]                  pwdata,
	output logic      [31:0]                  prdata,
	output logic                              pready,
	output logic                              pslverr,
	input  wire logic                         carrier_input_pin_one,
	input  wire logic                         carrier_input_pin_two,
	input  wire logic                         modulation_pin,
	input  wire logic                         reference_clock_signal,
	input  wire logic [mcs_pkg::N_PWM-1:0]    pwm_out,
	input  wire logic [mcs_pkg::N_PWM-1:0]    pwm_mode,
	input  wire logic [mcs_pkg::N_MOD_SRC-1:6] mod_src_onchip,
	output logic                              mod_out,
	output logic                              mod_out_oe,
	output logic                              mod_slew_limit,
	output logic [mcs_pkg::N_CAR_SRC-1:0]     carrier_pin_off,
	output logic [mcs_pkg::N_MOD_SRC-1:0]     mod_src_pin_off
);

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	logic [7:0]                    high_carrier_control;
	logic [7:0]                    low_carrier_control;
	logic [7:0]                    modulator_control;
	logic [7:0]                    modulation_source_control;
	logic [1:0]                    pin_meta;
	logic [1:0]                    pin_sync;
	logic [1:0]                    mod_pin_meta;
	logic                          mod_pin_sync;
	logic                          wr_en;
	logic                          addr_hit;
	logic [3:0]                    high_carrier_selector;
	logic [3:0]                    low_carrier_selector;
	logic                          high_carrier_invert;
	logic                          low_carrier_invert;
	logic                          high_carrier_sync;
	logic                          low_carrier_sync;
	logic                          high_carrier_pin_drive_off;
	logic                          low_carrier_pin_drive_off;
	logic                          modulator_enable;
	logic                          output_polarity;
	logic                          manual_modulation_bit;
	logic [3:0]                    mod_sel;
	logic [mcs_pkg::N_CAR_SRC-1:0] car_src;
	logic [mcs_pkg::N_CAR_SRC-1:0] high_pin_off;
	logic [mcs_pkg::N_CAR_SRC-1:0] low_pin_off;
	logic [mcs_pkg::N_MOD_SRC-1:0] mod_src;
	logic                          high_car;
	logic                          low_car;
	logic                          high_car_d;
	logic                          low_car_d;
	logic                          high_fall;
	logic                          low_fall;
	logic                          mod_level;
	logic                          sel_car;
	mcs_pkg::mcs_state_t           state;
	mcs_pkg::mcs_state_t           next_state;

	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			pin_meta     <= 2'h0;
			pin_sync     <= 2'h0;
			mod_pin_meta <= 2'h0;
		end else begin
			pin_meta     <= {carrier_input_pin_two, carrier_input_pin_one};
			pin_sync     <= pin_meta;
			mod_pin_meta <= {mod_pin_meta[0], modulation_pin};
		end
	end
	assign mod_pin_sync = mod_pin_meta[1];

	// ----------------------------------------------------------------
	// APB slave
	// ----------------------------------------------------------------
	assign pready   = 1'b1;
	assign addr_hit = (paddr == mcs_pkg::OFF_HIGH_CAR) || (paddr == mcs_pkg::OFF_LOW_CAR) ||
	                  (paddr == mcs_pkg::OFF_MOD_CON) || (paddr == mcs_pkg::OFF_MOD_SRC);
	assign pslverr  = psel & penable & ~addr_hit;
	assign wr_en    = psel & penable & pwrite & addr_hit;

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			high_carrier_control <= mcs_pkg::RST_REG;
		end else if (wr_en && paddr == mcs_pkg::OFF_HIGH_CAR) begin
			high_carrier_control <= pwdata[7:0] & mcs_pkg::MASK_CAR;
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			low_carrier_control <= mcs_pkg::RST_REG;
		end else if (wr_en && paddr == mcs_pkg::OFF_LOW_CAR) begin
			low_carrier_control <= pwdata[7:0] & mcs_pkg::MASK_CAR;
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			modulator_control <= mcs_pkg::RST_REG;
		end else if (wr_en && paddr == mcs_pkg::OFF_MOD_CON) begin
			modulator_control <= pwdata[7:0] & mcs_pkg::MASK_CON;
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			modulation_source_control <= mcs_pkg::RST_REG;
		end else if (wr_en && paddr == mcs_pkg::OFF_MOD_SRC) begin
			modulation_source_control <= pwdata[7:0] & mcs_pkg::MASK_SRC;
		end
	end

	// Read mux; the live output value appears in the control register
	always_comb begin
		prdata = 32'h0000_0000;
		case (paddr)
			mcs_pkg::OFF_HIGH_CAR: prdata[7:0] = high_carrier_control;
			mcs_pkg::OFF_LOW_CAR:  prdata[7:0] = low_carrier_control;
			mcs_pkg::OFF_MOD_CON: begin
				prdata[7:0] = modulator_control;
				prdata[mcs_pkg::BIT_OUT_VALUE] = mod_out;
			end
			mcs_pkg::OFF_MOD_SRC:  prdata[7:0] = modulation_source_control;
			default:               prdata = 32'h0000_0000;
		endcase
	end

	// ----------------------------------------------------------------
	// Field extraction
	// ----------------------------------------------------------------
	assign high_carrier_selector      = high_carrier_control[mcs_pkg::SEL_LSB +: mcs_pkg::SEL_W];
	assign low_carrier_selector       = low_carrier_control[mcs_pkg::SEL_LSB +: mcs_pkg::SEL_W];
	assign high_carrier_invert        = high_carrier_control[mcs_pkg::BIT_INVERT];
	assign low_carrier_invert         = low_carrier_control[mcs_pkg::BIT_INVERT];
	assign high_carrier_sync          = high_carrier_control[mcs_pkg::BIT_SYNC];
	assign low_carrier_sync           = low_carrier_control[mcs_pkg::BIT_SYNC];
	assign high_carrier_pin_drive_off = high_carrier_control[mcs_pkg::BIT_PIN_OFF];
	assign low_carrier_pin_drive_off  = low_carrier_control[mcs_pkg::BIT_PIN_OFF];
	assign modulator_enable           = modulator_control[mcs_pkg::BIT_ENABLE];
	assign output_polarity            = modulator_control[mcs_pkg::BIT_OUT_POL];
	assign manual_modulation_bit      = modulator_control[mcs_pkg::BIT_MANUAL];
	assign mod_sel                    = modulation_source_control[mcs_pkg::SEL_LSB +: mcs_pkg::SEL_W];

	// ----------------------------------------------------------------
	// Carrier channels
	// ----------------------------------------------------------------
	assign car_src = {pwm_out, reference_clock_signal, pin_sync, 1'b0};

	mcs_carrier_chan u_high (
		.mclk      (mclk),
		.rst_n     (rst_n),
		.sel       (high_carrier_selector),
		.invert    (high_carrier_invert),
		.drive_off (high_carrier_pin_drive_off),
		.src_in    (car_src),
		.pwm_mode  (pwm_mode),
		.carrier   (high_car),
		.pin_off   (high_pin_off)
	);

	mcs_carrier_chan u_low (
		.mclk      (mclk),
		.rst_n     (rst_n),
		.sel       (low_carrier_selector),
		.invert    (low_carrier_invert),
		.drive_off (low_carrier_pin_drive_off),
		.src_in    (car_src),
		.pwm_mode  (pwm_mode),
		.carrier   (low_car),
		.pin_off   (low_pin_off)
	);

	assign carrier_pin_off = high_pin_off | low_pin_off;

	// ----------------------------------------------------------------
	// Modulation level
	// ----------------------------------------------------------------
	assign mod_src[mcs_pkg::MOD_MANUAL]                = manual_modulation_bit;
	assign mod_src[mcs_pkg::MOD_PIN]                   = mod_pin_sync;
	assign mod_src[mcs_pkg::MOD_PWM_LO +: mcs_pkg::N_PWM] = pwm_out & pwm_mode;
	assign mod_src[mcs_pkg::N_MOD_SRC-1:6]             = mod_src_onchip;

	assign mod_level = (mod_sel < 4'(mcs_pkg::N_MOD_SRC)) ? mod_src[mod_sel] : 1'b0;

	genvar mi;
	generate
		for (mi = 0; mi < mcs_pkg::N_MOD_SRC; mi++) begin : g_msoff
			assign mod_src_pin_off[mi] = modulation_source_control[mcs_pkg::BIT_SRC_OFF] & (mod_sel == 4'(mi));
		end
	endgenerate

	// ----------------------------------------------------------------
	// Carrier switching
	// ----------------------------------------------------------------
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			high_car_d <= 1'b0;
			low_car_d  <= 1'b0;
		end else begin
			high_car_d <= high_car;
			low_car_d  <= low_car;
		end
	end
	assign high_fall = high_car_d & ~high_car;
	assign low_fall  = low_car_d & ~low_car;

	always_comb begin
		next_state = state;
		case (state)
			mcs_pkg::MCS_ON_HIGH: begin
				if (!mod_level && (!high_carrier_sync || high_fall)) begin
					next_state = mcs_pkg::MCS_ON_LOW;
				end
			end
			mcs_pkg::MCS_ON_LOW: begin
				if (mod_level && (!low_carrier_sync || low_fall)) begin
					next_state = mcs_pkg::MCS_ON_HIGH;
				end
			end
			default: next_state = mcs_pkg::MCS_ON_LOW;
		endcase
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			state <= mcs_pkg::MCS_ON_LOW;
		end else begin
			state <= next_state;
		end
	end

	// ----------------------------------------------------------------
	// Output stage
	// ----------------------------------------------------------------
	assign sel_car = (state == mcs_pkg::MCS_ON_HIGH) ? high_car : low_car;

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			mod_out <= 1'b0;
		end else if (!modulator_enable) begin
			mod_out <= 1'b0;
		end else begin
			mod_out <= sel_car ^ output_polarity;
		end
	end

	assign mod_out_oe     = modulator_enable & modulator_control[mcs_pkg::BIT_PIN_OE];
	assign mod_slew_limit = modulator_control[mcs_pkg::BIT_SLEW];

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	property p_high_pin_off;
		@(posedge mclk) disable iff (!rst_n)
		high_carrier_pin_drive_off && !high_carrier_selector[3] |=> carrier_pin_off[$past(high_carrier_selector[2:0])];
	endproperty
	a_high_pin_off: assert property (p_high_pin_off) else $error("high pin drive not disabled");

	property p_high_invert;
		@(posedge mclk) disable iff (!rst_n)
		high_carrier_selector == mcs_pkg::CAR_REFCLK && high_carrier_invert |=> high_car == !$past(reference_clock_signal);
	endproperty
	a_high_invert: assert property (p_high_invert) else $error("high carrier not inverted");

	property p_high_sync_hold;
		@(posedge mclk) disable iff (!rst_n)
		state == mcs_pkg::MCS_ON_HIGH && high_carrier_sync && !high_fall |=> state == mcs_pkg::MCS_ON_HIGH;
	endproperty
	a_high_sync_hold: assert property (p_high_sync_hold) else $error("switch to low without falling edge");

	property p_high_pin_one;
		@(posedge mclk) disable iff (!rst_n)
		high_carrier_selector == mcs_pkg::CAR_PIN_ONE && !high_carrier_invert |=> high_car == $past(pin_sync[0]);
	endproperty
	a_high_pin_one: assert property (p_high_pin_one) else $error("high carrier not pin one");

	property p_reserved;
		@(posedge mclk) disable iff (!rst_n)
		high_carrier_selector[3] |=> high_car == $past(high_carrier_invert);
	endproperty
	a_reserved: assert property (p_reserved) else $error("reserved code drives carrier");

	property p_pwm_gate;
		@(posedge mclk) disable iff (!rst_n)
		low_carrier_selector == mcs_pkg::CAR_PWM_ONE && !pwm_mode[0] && !low_carrier_invert |=> !low_car;
	endproperty
	a_pwm_gate: assert property (p_pwm_gate) else $error("PWM carrier outside PWM mode");

	property p_unused_bit;
		@(posedge mclk) disable iff (!rst_n)
		psel && !pwrite && (paddr == mcs_pkg::OFF_HIGH_CAR || paddr == mcs_pkg::OFF_LOW_CAR) |-> !prdata[mcs_pkg::BIT_UNUSED];
	endproperty
	a_unused_bit: assert property (p_unused_bit) else $error("unused carrier bit reads one");

	property p_low_pin_off;
		@(posedge mclk) disable iff (!rst_n)
		low_carrier_pin_drive_off && !low_carrier_selector[3] |=> carrier_pin_off[$past(low_carrier_selector[2:0])];
	endproperty
	a_low_pin_off: assert property (p_low_pin_off) else $error("low pin drive not disabled");

	property p_low_invert;
		@(posedge mclk) disable iff (!rst_n)
		low_carrier_selector == mcs_pkg::CAR_REFCLK && low_carrier_invert |=> low_car == !$past(reference_clock_signal);
	endproperty
	a_low_invert: assert property (p_low_invert) else $error("low carrier not inverted");

	property p_low_sync_hold;
		@(posedge mclk) disable iff (!rst_n)
		state == mcs_pkg::MCS_ON_LOW && low_carrier_sync && !low_fall |=> state == mcs_pkg::MCS_ON_LOW;
	endproperty
	a_low_sync_hold: assert property (p_low_sync_hold) else $error("switch to high without falling edge");

	property p_low_pin_two;
		@(posedge mclk) disable iff (!rst_n)
		low_carrier_selector == mcs_pkg::CAR_PIN_TWO && !low_carrier_invert |=> low_car == $past(pin_sync[1]);
	endproperty
	a_low_pin_two: assert property (p_low_pin_two) else $error("low carrier not pin two");

	property p_disabled;
		@(posedge mclk) disable iff (!rst_n)
		!modulator_enable [*2] |-> !mod_out;
	endproperty
	a_disabled: assert property (p_disabled) else $error("output while disabled");

	property p_manual;
		@(posedge mclk) disable iff (!rst_n)
		mod_sel == mcs_pkg::MOD_MANUAL && manual_modulation_bit && !low_carrier_sync && state == mcs_pkg::MCS_ON_LOW
		|=> state == mcs_pkg::MCS_ON_HIGH;
	endproperty
	a_manual: assert property (p_manual) else $error("manual bit did not select high");

	property p_polarity;
		@(posedge mclk) disable iff (!rst_n)
		modulator_enable && output_polarity |=> mod_out == !$past(sel_car);
	endproperty
	a_polarity: assert property (p_polarity) else $error("output not inverted");

	property p_follow_high;
		@(posedge mclk) disable iff (!rst_n)
		modulator_enable && !output_polarity && state == mcs_pkg::MCS_ON_HIGH |=> mod_out == $past(high_car);
	endproperty
	a_follow_high: assert property (p_follow_high) else $error("output not following high carrier");

endmodule

/* File: mcs_src_model.sv */
// Partner model of the on-chip carrier and modulation sources
`timescale 1ns/1ps
module mcs_src_model (
	input  wire logic [12:0] drv,
	output logic             pin_one,
	output logic             pin_two,
	output logic             ref_clk,
	output logic [3:0]       pwm,
	output logic             mod_pin,
	output logic [10:6]      onchip
);
	// Levels change only just after an mclk edge, as the bench sets them
	assign {onchip, mod_pin, pwm, ref_clk, pin_two, pin_one} = drv;
endmodule

/* File: tb_top.sv */
// Self-checking testbench of the carrier select block
`timescale 1ns/1ps
module tb_top;
	logic        mclk;
	logic        rst_n;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic [3:0]  pwm_mode;
	logic [12:0] drv;
	logic        pin_one;
	logic        pin_two;
	logic        ref_clk;
	logic [3:0]  pwm;
	logic        mod_pin;
	logic [10:6] onchip;
	logic        mod_out;
	logic [7:0]  pin_off;
	int          err_count;
	int          tests_run;
	logic [31:0] rnd;
	logic [31:0] rd;
	logic        er;
	logic [7:0]  hr;
	logic [7:0]  lr;
	logic [7:0]  con;
	logic [7:0]  ep;
	logic [7:0]  ms;
	logic [10:0] msoff;
	logic        mo;
	logic        oe;
	logic        slew;

	mcs_src_model src (.drv(drv), .pin_one(pin_one), .pin_two(pin_two), .ref_clk(ref_clk), .pwm(pwm),
		.mod_pin(mod_pin), .onchip(onchip));
	mcs_carrier_select uut (.mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.carrier_input_pin_one(pin_one), .carrier_input_pin_two(pin_two), .modulation_pin(mod_pin),
		.reference_clock_signal(ref_clk), .pwm_out(pwm), .pwm_mode(pwm_mode), .mod_src_onchip(onchip),
		.mod_out(mod_out), .mod_out_oe(oe), .mod_slew_limit(slew), .carrier_pin_off(pin_off),
		.mod_src_pin_off(msoff));

	initial begin
		mclk = 1'b0;
		forever #2 mclk = ~mclk;
	end

	// ----------
	// Model and bus tasks
	// ----------
	function automatic logic [31:0] next_rnd(input logic [31:0] x);
		return {x[30:0], 1'b0} ^ (x[31] ? 32'h04c11db7 : 32'h0);
	endfunction

	// Processed carrier of one channel register, from the source levels
	function automatic logic car(input logic [7:0] r);
		int c;
		c = r[3:0];
		return ((c >= 1 && c <= 7) ? drv[c-1] & (c < 4 || pwm_mode[c-4]) : 1'b0) ^ r[6];
	endfunction

	// Modulation level for a source code: manual bit, pin, gated PWM units, other on-chip sources
	function automatic logic mlev(input int c, input logic m);
		return (c == 0) ? m : (c == 1) ? drv[7] : (c <= 5) ? drv[c+1] & pwm_mode[c-2] :
			(c <= 10) ? drv[c+2] : 1'b0;
	endfunction

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			err_count++;
			$display("ERROR %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
		@(posedge mclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= {24'h0, d};
		@(posedge mclk);
		penable <= 1'b1;
		do @(posedge mclk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	// Carrier on one channel from pin one, switch away with or without sync
	task automatic sync_run(input logic ch, input logic s);
		apb(1'b1, mcs_pkg::OFF_HIGH_CAR, 8'h00);
		apb(1'b1, mcs_pkg::OFF_LOW_CAR, 8'h00);
		apb(1'b1, ch ? mcs_pkg::OFF_LOW_CAR : mcs_pkg::OFF_HIGH_CAR, {2'b00, s, 5'h01});
		drv <= 13'h0001;
		apb(1'b1, mcs_pkg::OFF_MOD_CON, {7'h40, ~ch});
		repeat (8) @(posedge mclk);
		chk(mod_out, 1);
		apb(1'b1, mcs_pkg::OFF_MOD_CON, {7'h40, ch});
		repeat (8) @(posedge mclk);
		chk(mod_out, s);
		drv <= 13'h0000;
		repeat (8) @(posedge mclk);
		drv <= 13'h0001;
		repeat (8) @(posedge mclk);
		chk(mod_out, 0);
	endtask

	task automatic close_out;
		$display("Checks %0d, mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// ----------
	// Stimulus
	// ----------
	initial begin
		repeat (20000) @(posedge mclk);
		err_count++;
		close_out();
	end

	initial begin
		rnd = 32'h4c75f7a4;
		{psel, penable, pwrite, paddr, pwdata, pwm_mode, drv} = '0;
		err_count = 0;
		tests_run = 0;
		rst_n = 1'b0;
		repeat (10) @(posedge mclk);
		rst_n <= 1'b1;
		for (int i = 0; i < 4; i++) begin
			apb(1'b0, 12'(4 * i), 8'h00);
			chk(rd, 0);
			chk(er, 0);
		end
		apb(1'b1, 12'h010, 8'hff);
		chk(er, 1);
		apb(1'b0, 12'h010, 8'h00);
		chk(rd, 0);
		for (int i = 0; i < 32; i++) begin
			rnd = next_rnd(rnd);
			hr = {rnd[7:6], 1'b0, rnd[4], 4'(i)};
			lr = {rnd[15:14], 1'b0, rnd[12], 4'(i + 5)};
			con = {rnd[21] | rnd[22], rnd[17], rnd[18], rnd[19], 3'b000, rnd[16]};
			drv <= rnd[31:19];
			pwm_mode <= rnd[11:8];
			apb(1'b1, mcs_pkg::OFF_HIGH_CAR, hr);
			apb(1'b1, mcs_pkg::OFF_LOW_CAR, lr);
			apb(1'b1, mcs_pkg::OFF_MOD_CON, con);
			repeat (8) @(posedge mclk);
			for (int c = 0; c < 8; c++)
				ep[c] = (hr[3:0] == c && hr[7]) || (lr[3:0] == c && lr[7]);
			mo = con[7] & ((con[0] ? car(hr) : car(lr)) ^ con[4]);
			chk(mod_out, mo);
			chk(pin_off, ep);
			chk(oe, con[7] & con[6]);
			chk(slew, con[5]);
			apb(1'b0, mcs_pkg::OFF_MOD_CON, 8'h00);
			chk(rd, con | {4'h0, mo, 3'h0});
			apb(1'b0, mcs_pkg::OFF_HIGH_CAR, 8'h00);
			chk(rd, hr & 8'hef);
			apb(1'b0, mcs_pkg::OFF_LOW_CAR, 8'h00);
			chk(rd, lr & 8'hef);
		end
		// ----------
		// Modulation source codes, high carrier held at one and low at zero
		// ----------
		apb(1'b1, mcs_pkg::OFF_HIGH_CAR, 8'h48);
		apb(1'b1, mcs_pkg::OFF_LOW_CAR, 8'h00);
		for (int i = 0; i < 16; i++) begin
			rnd = next_rnd(rnd);
			ms = {rnd[3], 3'b000, 4'(i)};
			drv <= rnd[31:19];
			pwm_mode <= rnd[11:8];
			apb(1'b1, mcs_pkg::OFF_MOD_CON, {7'h40, rnd[16]});
			apb(1'b1, mcs_pkg::OFF_MOD_SRC, ms);
			repeat (8) @(posedge mclk);
			chk(mod_out, mlev(i, rnd[16]));
			chk(msoff, (ms[7] && i < 11) ? 32'h1 << i : 32'h0);
			apb(1'b0, mcs_pkg::OFF_MOD_SRC, 8'h00);
			chk(rd, ms);
		end
		// Reset in mid-run clears every register and the output
		rst_n <= 1'b0;
		repeat (3) @(posedge mclk);
		chk(mod_out, 0);
		chk(oe, 0);
		rst_n <= 1'b1;
		for (int i = 0; i < 4; i++) begin
			apb(1'b0, 12'(4 * i), 8'h00);
			chk(rd, 0);
		end
		for (int s = 0; s < 2; s++) begin
			sync_run(1'b0, 1'(s));
			sync_run(1'b1, 1'(s));
		end
		close_out();
	end
endmodule
